// ===== timer_capture_compare.sv
// Purpose: 16-bit timer, shared counter, channels for capture, compare, edge and centre pwm
// Assumes: AXI4-Lite master keeps valid and payload stable until ready; debug_halt on aclk
// Notes:   prescaler left out; one tick per selected clock event
// Overview of operation
// - edge/level 00 releases the pin from timer control, whatever the mode bits
// - capture mode: 01 rising, 10 falling, 11 either edge
// - compare mode: on match 01 toggles, 10 drives low, 11 drives high
// - edge pwm: 10 high-true cleared on compare, X1 low-true set on compare
// - centre select forces centre pwm on all channels, polarity from edge/level
// - reset clears every channel value register
// - capture mode: reading one byte latches both until the other is read
// - any channel control write unlatches the value coherency state
// - capture mode ignores processor writes to the value bytes
// - debug halt reads return live value and leave the latch alone
// - compare/pwm writes go to a buffer, moved as one word when complete
// - clock off loads at second byte; compare with clock loads at next count
// - pwm with clock loads as counter steps top minus one to top
// - debug halt writes go straight to the active value register
// - debug halt writes leave a partial buffered sequence intact
// - one centre select bit drives all channels and up/down counting
// - clock select: off, bus clock, fixed clock tick, external pin
// - clock select resets to off; writing off freezes without other change
// - external clock is synchronised; source at most a quarter of bus clock
// - wrap irq is a level while flag and enable are both one
// - up counting sets wrap flag on wrap to zero from top
// - centre mode sets wrap flag on turning down at the modulus
// - channel flag on capture edge or match, not at 0% or 100% duty
// - flag clears by read while set then write zero; new event wins
// - capture edge copies the counter into the channel value
// - centre mode counts up to top then down to zero, else wraps
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module timer_capture_compare
    import timer_pkg::*;
#(
    parameter int unsigned NCH    = 2,
    parameter int unsigned EXT_CH = 0
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              debug_halt_mode,
    input  wire logic              fixed_clk_tick,
    input  wire logic [NCH-1:0]    chan_pin_in,
    output logic [NCH-1:0]         chan_pin_out,
    output logic [NCH-1:0]         chan_pin_oe,
    output logic                   wrap_irq,
    output logic [NCH-1:0]         chan_irq
);

    // ---------------- bus slave ----------------
    logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic        wr_hs, rd_hs;
    logic [3:0]  aw_idx, ar_idx;
    logic [1:0]  aw_sub, ar_sub;
    logic        aw_ok, ar_ok;
    logic [31:0] rd_word;

    assign wr_hs  = awready_ff;
    assign rd_hs  = arready_ff;
    assign aw_idx = s_axi_awaddr[7:4];
    assign aw_sub = s_axi_awaddr[3:2];
    assign ar_idx = s_axi_araddr[7:4];
    assign ar_sub = s_axi_araddr[3:2];

    function automatic logic addr_ok(input logic [3:0] idx, input logic [1:0] sub);
        logic ok;
        ok = 1'b0;
        if (idx == TIMER_SLOT) begin
            ok = (sub != 2'h3);
        end else if (idx < 4'(NCH + 1)) begin
            ok = (sub != 2'h3);
        end
        return ok;
    endfunction : addr_ok

    assign aw_ok = addr_ok(aw_idx, aw_sub);
    assign ar_ok = addr_ok(ar_idx, ar_sub);

    // write address and data are taken together in one cycle, one write outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
            if (wr_hs) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= aw_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 32'h00000000;
        end else begin
            arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
            if (rd_hs) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= ar_ok ? RESP_OKAY : RESP_SLVERR;
                rdata_ff  <= ar_ok ? rd_word : 32'h00000000;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = awready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;

    logic tsc_wr, tsc_rd, cnt_wr, mod_wr;
    assign tsc_wr = wr_hs & (s_axi_awaddr == TSC_OFF) & s_axi_wstrb[0];
    assign tsc_rd = rd_hs & (s_axi_araddr == TSC_OFF);
    assign cnt_wr = wr_hs & (s_axi_awaddr == CNT_OFF) & (s_axi_wstrb[1:0] != 2'h0);
    assign mod_wr = wr_hs & (s_axi_awaddr == MOD_OFF);

    // ---------------- timer control and counter ----------------
    timer_ctrl_s tctrl_ff;
    logic [15:0] cnt_ff, mod_ff, top, nxt_cnt;
    logic        down_ff, nxt_down, wrap_ev, tick, cnt_moved_ff, step_to_top;
    logic        wrap_flag_ff, wrap_arm_ff, wrap_irq_ff;
    logic [NCH-1:0] pin_s1_ff, pin_s2_ff, pin_d_ff;

    // pin synchronisers; stage one feeds stage two only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_d_ff  <= '0;
        end else begin
            pin_s1_ff <= chan_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff  <= pin_s2_ff;
        end
    end

    // counter is frozen while halted so captures see a stable count
    always_comb begin
        case (tctrl_ff.clock_select)
            CLK_BUS:   tick = 1'b1;
            CLK_FIXED: tick = fixed_clk_tick;
            CLK_EXT:   tick = pin_s2_ff[EXT_CH] & ~pin_d_ff[EXT_CH];
            default:   tick = 1'b0;
        endcase
        if (debug_halt_mode) begin
            tick = 1'b0;
        end
    end

    assign top = (mod_ff == MOD_RST) ? FREE_TOP : mod_ff;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_down = 1'b0;
        wrap_ev  = 1'b0;
        if (tctrl_ff.centre_align_select) begin
            if (!down_ff) begin
                if (cnt_ff == top) begin
                    nxt_cnt  = cnt_ff - 16'h0001;
                    nxt_down = 1'b1;
                    wrap_ev  = tick;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end else if (cnt_ff == CNT_RST) begin
                nxt_cnt = cnt_ff + 16'h0001;
            end else begin
                nxt_cnt  = cnt_ff - 16'h0001;
                nxt_down = 1'b1;
            end
        end else if (cnt_ff == top) begin
            nxt_cnt = CNT_RST;
            wrap_ev = tick;
        end else begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    // pwm reload point: rising step onto the terminal count
    assign step_to_top = tick & ~down_ff & (cnt_ff != top) & (nxt_cnt == top);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff       <= CNT_RST;
            down_ff      <= 1'b0;
            cnt_moved_ff <= 1'b0;
        end else begin
            cnt_moved_ff <= tick & ~cnt_wr;
            if (cnt_wr) begin
                cnt_ff  <= CNT_RST;
                down_ff <= 1'b0;
            end else if (tick) begin
                cnt_ff  <= nxt_cnt;
                down_ff <= nxt_down;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tctrl_ff <= TCTRL_RST;
            mod_ff   <= MOD_RST;
        end else begin
            if (tsc_wr) begin
                tctrl_ff <= timer_ctrl_s'(s_axi_wdata[TSC_CTRL_LSB +: 4]);
            end
            if (mod_wr && s_axi_wstrb[0]) begin
                mod_ff[7:0] <= s_axi_wdata[7:0];
            end
            if (mod_wr && s_axi_wstrb[1]) begin
                mod_ff[15:8] <= s_axi_wdata[15:8];
            end
        end
    end

    // wrap flag: a new wrap sets and disarms, so a pending clear never loses it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_flag_ff <= 1'b0;
            wrap_arm_ff  <= 1'b0;
            wrap_irq_ff  <= 1'b0;
        end else begin
            if (wrap_ev) begin
                wrap_flag_ff <= 1'b1;
                wrap_arm_ff  <= 1'b0;
            end else if (tsc_wr && wrap_arm_ff && !s_axi_wdata[FLAG_BIT]) begin
                wrap_flag_ff <= 1'b0;
                wrap_arm_ff  <= 1'b0;
            end else if (tsc_rd && wrap_flag_ff) begin
                wrap_arm_ff <= 1'b1;
            end
            wrap_irq_ff <= wrap_flag_ff & tctrl_ff.wrap_irq_enable;
        end
    end

    assign wrap_irq = wrap_irq_ff;

    // ---------------- channels ----------------
    logic [31:0] ch_rd_word [NCH];

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        chan_ctrl_s  ctrl_ff;
        logic [15:0] val_ff, rbuf_ff;
        logic [7:0]  buf_hi_ff, buf_lo_ff, new_hi, new_lo, vh_byte, vl_byte;
        logic        flag_ff, arm_ff, hi_done_ff, lo_done_ff, rd_lat_ff, first_hi_ff;
        logic        out_ff, oe_ff, irq_ff;
        logic        hit_w, hit_r, sc_wr, vh_wr, vl_wr, sc_rd, vh_rd, vl_rd;
        logic        is_ic, is_oc, is_pwm, released, cap_ev, match_ev, duty_ok;
        logic        wr_hi_n, wr_lo_n, full, load_now, active, rise, fall;

        assign hit_w = wr_hs & (aw_idx == 4'(g + 1));
        assign hit_r = rd_hs & (ar_idx == 4'(g + 1));
        assign sc_wr = hit_w & (aw_sub == CH_SC_SUB) & s_axi_wstrb[0];
        assign vh_wr = hit_w & (aw_sub == CH_VH_SUB) & s_axi_wstrb[0];
        assign vl_wr = hit_w & (aw_sub == CH_VL_SUB) & s_axi_wstrb[0];
        assign sc_rd = hit_r & (ar_sub == CH_SC_SUB);
        assign vh_rd = hit_r & (ar_sub == CH_VH_SUB);
        assign vl_rd = hit_r & (ar_sub == CH_VL_SUB);

        assign released = (ctrl_ff.edge_level == EL_RELEASE);
        assign is_ic  = ~tctrl_ff.centre_align_select & (ctrl_ff.channel_mode == MS_CAPTURE);
        assign is_oc  = ~tctrl_ff.centre_align_select & (ctrl_ff.channel_mode == MS_COMPARE);
        assign is_pwm = tctrl_ff.centre_align_select | ctrl_ff.channel_mode[1];

        assign rise = pin_s2_ff[g] & ~pin_d_ff[g];
        assign fall = ~pin_s2_ff[g] & pin_d_ff[g];
        always_comb begin
            case (ctrl_ff.edge_level)
                EL_RISE: cap_ev = rise;
                EL_FALL: cap_ev = fall;
                EL_BOTH: cap_ev = rise | fall;
                default: cap_ev = 1'b0;
            endcase
            if (!is_ic) begin
                cap_ev = 1'b0;
            end
        end

        assign match_ev = cnt_moved_ff & (cnt_ff == val_ff);
        // no compare event when the duty is pinned at 0% or 100%
        assign duty_ok = (val_ff != VAL_RST) & (val_ff <= top)
                       & ~(tctrl_ff.centre_align_select & val_ff[15]);

        // buffered writes, refused in capture mode and bypassed while halted
        assign wr_hi_n = vh_wr & ~is_ic & ~debug_halt_mode;
        assign wr_lo_n = vl_wr & ~is_ic & ~debug_halt_mode;
        assign new_hi  = wr_hi_n ? s_axi_wdata[7:0] : buf_hi_ff;
        assign new_lo  = wr_lo_n ? s_axi_wdata[7:0] : buf_lo_ff;
        assign full    = (hi_done_ff | wr_hi_n) & (lo_done_ff | wr_lo_n);
        always_comb begin
            if (tctrl_ff.clock_select == CLK_OFF) begin
                load_now = full;
            end else if (is_oc) begin
                load_now = full & tick;
            end else if (is_pwm) begin
                load_now = full & step_to_top;
            end else begin
                load_now = 1'b0;
            end
            if (debug_halt_mode || sc_wr) begin
                load_now = 1'b0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_ff <= CCTRL_RST;
            end else if (sc_wr) begin
                ctrl_ff <= chan_ctrl_s'(s_axi_wdata[CSC_CTRL_LSB +: 5]);
            end
        end

        // write buffer and active value
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                val_ff     <= VAL_RST;
                buf_hi_ff  <= 8'h00;
                buf_lo_ff  <= 8'h00;
                hi_done_ff <= 1'b0;
                lo_done_ff <= 1'b0;
            end else begin
                buf_hi_ff <= new_hi;
                buf_lo_ff <= new_lo;
                if (sc_wr) begin
                    hi_done_ff <= 1'b0;
                    lo_done_ff <= 1'b0;
                end else if (load_now) begin
                    hi_done_ff <= 1'b0;
                    lo_done_ff <= 1'b0;
                end else begin
                    hi_done_ff <= hi_done_ff | wr_hi_n;
                    lo_done_ff <= lo_done_ff | wr_lo_n;
                end
                if (cap_ev) begin
                    val_ff <= cnt_ff;
                end else if (debug_halt_mode && !is_ic && vh_wr) begin
                    val_ff[15:8] <= s_axi_wdata[7:0];
                end else if (debug_halt_mode && !is_ic && vl_wr) begin
                    val_ff[7:0] <= s_axi_wdata[7:0];
                end else if (load_now) begin
                    val_ff <= {new_hi, new_lo};
                end
            end
        end

        // read coherency latch, untouched by reads while halted; a control write still clears it
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rd_lat_ff   <= 1'b0;
                first_hi_ff <= 1'b0;
                rbuf_ff     <= VAL_RST;
            end else if (sc_wr) begin
                rd_lat_ff <= 1'b0;
            end else if ((vh_rd || vl_rd) && is_ic && !debug_halt_mode) begin
                if (!rd_lat_ff) begin
                    rd_lat_ff   <= 1'b1;
                    first_hi_ff <= vh_rd;
                    rbuf_ff     <= val_ff;
                end else if (vh_rd != first_hi_ff) begin
                    rd_lat_ff <= 1'b0;
                end
            end
        end

        assign vh_byte = (is_ic && rd_lat_ff && !debug_halt_mode) ? rbuf_ff[15:8] : val_ff[15:8];
        assign vl_byte = (is_ic && rd_lat_ff && !debug_halt_mode) ? rbuf_ff[7:0] : val_ff[7:0];

        always_comb begin
            case (ar_sub)
                CH_SC_SUB: ch_rd_word[g] = {24'h000000, flag_ff, ctrl_ff, 2'h0};
                CH_VH_SUB: ch_rd_word[g] = {24'h000000, vh_byte};
                CH_VL_SUB: ch_rd_word[g] = {24'h000000, vl_byte};
                default:   ch_rd_word[g] = 32'h00000000;
            endcase
        end

        // channel flag with read-then-write-zero clear; a new event wins
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                flag_ff <= 1'b0;
                arm_ff  <= 1'b0;
                irq_ff  <= 1'b0;
            end else begin
                if (cap_ev || (match_ev && (is_oc || (is_pwm && duty_ok)))) begin
                    flag_ff <= 1'b1;
                    arm_ff  <= 1'b0;
                end else if (sc_wr && arm_ff && !s_axi_wdata[FLAG_BIT]) begin
                    flag_ff <= 1'b0;
                    arm_ff  <= 1'b0;
                end else if (sc_rd && flag_ff) begin
                    arm_ff <= 1'b1;
                end
                irq_ff <= flag_ff & ctrl_ff.channel_irq_enable;
            end
        end

        // pwm level: active while count is below the value, inverted for low-true
        assign active = (cnt_ff < val_ff) & ~(tctrl_ff.centre_align_select & val_ff[15]);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                out_ff <= 1'b0;
                oe_ff  <= 1'b0;
            end else begin
                oe_ff <= ~released & ~is_ic;
                if (is_pwm && !released) begin
                    out_ff <= active ^ ctrl_ff.edge_level[0];
                end else if (is_oc && match_ev) begin
                    case (ctrl_ff.edge_level)
                        EL_RISE: out_ff <= ~out_ff;
                        EL_FALL: out_ff <= 1'b0;
                        EL_BOTH: out_ff <= 1'b1;
                        default: out_ff <= out_ff;
                    endcase
                end
            end
        end

        assign chan_pin_out[g] = out_ff;
        assign chan_pin_oe[g]  = oe_ff;
        assign chan_irq[g]     = irq_ff;
    end : g_ch

    // ---------------- read mux ----------------
    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            TSC_OFF: rd_word = {24'h000000, wrap_flag_ff, tctrl_ff, 3'h0};
            CNT_OFF: rd_word = {16'h0000, cnt_ff};
            MOD_OFF: rd_word = {16'h0000, mod_ff};
            default: rd_word = 32'h00000000;
        endcase
        for (int c = 0; c < NCH; c++) begin
            if (ar_idx == 4'(c + 1)) begin
                rd_word = ch_rd_word[c];
            end
        end
    end

endmodule : timer_capture_compare

// ===== timer_capture_compare_props.sv
// Purpose: bus and reset checks
// Assumes: one clock, sync low reset
// Notes:   bound to the timer top
`timescale 1ns/10ps
module timer_capture_compare_props
    import timer_pkg::*;
#(parameter int unsigned NCH = 2) (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_wready,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire logic [31:0]    s_axi_rdata,
    input wire logic [NCH-1:0] chan_pin_oe,
    input wire logic           wrap_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_AW_W_PAIR:
    assert property (s_axi_awready == s_axi_wready) else $error("ready split");
    AST_AW_PULSE:
    assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid) else $error("aw pulse");
    AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b drop");
    AST_NO_AW_IN_B:
    assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw in b");
    AST_R_NEXT:
    assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("r late");
    AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r drop");
    AST_AR_WAIT:
    assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |-> ##[1:2] s_axi_arready) else $error("ar");
    AST_RST_QUIET:
    assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && chan_pin_oe == '0 && !wrap_irq)
        else $error("not idle");
endmodule : timer_capture_compare_props
bind timer_capture_compare timer_capture_compare_props #(.NCH(NCH)) u_props (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .chan_pin_oe, .wrap_irq);

// ===== timer_capture_compare_test.sv
// Purpose: register-level test of the timer
// Assumes: AXI4-Lite master, 8 ns clock
// Notes:   channel 0 compare, channel 1 capture
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s %h %h", n, e, g); end end
`define WT(s) begin k = 0; do begin @(posedge aclk); k++; end while (!(s) && k < 300); if (!(s)) begin n_fail++; tally_and_finish; end end
module timer_capture_compare_test;
    import timer_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0, halt = 1'h0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_d, c;
    logic [1:0] bresp, rresp, rd_r, pin_in, pin_out, pin_oe, cirq, lvl = '0;
    logic awready, wready, bvalid, arready, rvalid, wirq;
    int n_fail = 0, total_checks = 0, k;
    timer_capture_compare u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .debug_halt_mode(halt), .fixed_clk_tick(1'h0), .chan_pin_in(pin_in),
        .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .wrap_irq(wirq), .chan_irq(cirq));
    timer_pins_model u_pins (.level_req(lvl), .aclk, .pin_out, .pin_oe, .pin_in);
    always #4 aclk = ~aclk;
    task automatic tally_and_finish;
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a; wdata <= {24'h0, d}; awv <= 1'h1; wv <= 1'h1;
        `WT(awready)
        awv <= 1'h0; wv <= 1'h0;
        @(posedge aclk);
        bready <= 1'h1;
        `WT(bvalid)
        bready <= 1'h0;
        rd_r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a; arv <= 1'h1;
        `WT(arready)
        arv <= 1'h0;
        @(posedge aclk);
        rready <= 1'h1;
        `WT(rvalid)
        rready <= 1'h0; rd_d = rdata; rd_r = rresp;
    endtask : rd
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h14); `CHK("vh", 32'h0, rd_d)
        rd(8'h00); `CHK("tsc", 32'h0, rd_d)
        rd(8'h1C); `CHK("resp", RESP_SLVERR, rd_r)
        wr(8'h1C, 8'h00); `CHK("bresp", RESP_SLVERR, rd_r)
        wr(8'h10, 8'h5C); `CHK("oe", 2'h1, pin_oe)
        wr(8'h18, 8'h40); rd(8'h18); `CHK("buf", 32'h0, rd_d)
        wr(8'h14, 8'h00); rd(8'h18); `CHK("vl", 32'h40, rd_d)
        halt <= 1'h1;
        wr(8'h18, 8'h50); rd(8'h18); `CHK("halt", 32'h50, rd_d)
        halt <= 1'h0;
        wr(8'h00, 8'h08);
        `WT(cirq[0])
        repeat (2) @(posedge aclk);
        `CHK("set", 1'h1, pin_out[0])
        wr(8'h00, 8'h00); rd(8'h04); c = rd_d; rd(8'h04); `CHK("hold", c, rd_d)
        wr(8'h10, 8'h50); `CHK("rel", 2'h0, pin_oe)
        wr(8'h20, 8'h44); wr(8'h24, 8'hAA); rd(8'h24); `CHK("ro", 32'h0, rd_d)
        lvl <= 2'h2;
        `WT(cirq[1])
        rd(8'h28); `CHK("lat", 32'h0, rd_d)
        rd(8'h28); `CHK("cap", {24'h0, c[7:0]}, rd_d)
        rd(8'h20); wr(8'h20, 8'h44); `CHK("clr", 1'h0, cirq[1])
        wr(8'h04, 8'h00); wr(8'h08, 8'h03); wr(8'h00, 8'h48);
        `WT(wirq)
        rd(8'h00); `CHK("wrap", 1'h1, rd_d[7])
        wr(8'h10, 8'h24); `CHK("edge_pwm_mode", 1'h0, pin_out[0])
        wr(8'h14, 8'h00); wr(8'h18, 8'h00);
        repeat (8) @(posedge aclk);
        `CHK("load", 1'h1, pin_out[0])
        tally_and_finish;
    end
endmodule : timer_capture_compare_test

// ===== timer_pins_model.sv
// Purpose: outside source on the channel pins
// Assumes: bench sets level_req
// Notes:   wire follows the timer while it drives
`timescale 1ns/10ps
module timer_pins_model #(parameter int unsigned NCH = 2) (
    input  wire logic [NCH-1:0] level_req,
    input  wire logic           aclk,
    input  wire logic [NCH-1:0] pin_out,
    input  wire logic [NCH-1:0] pin_oe,
    output logic      [NCH-1:0] pin_in
);
    logic [NCH-1:0] src_ff = '0;
    logic [1:0]     pace_ff = '0;
    // source may move only every fourth bus cycle
    always_ff @(posedge aclk) begin
        pace_ff <= pace_ff + 2'h1;
        if (pace_ff == 2'h3) src_ff <= level_req;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_ff);
endmodule : timer_pins_model

// ===== timer_pkg.sv
// Purpose: shared constants and carriers for the timer with capture/compare/pwm channels
// Assumes: AXI4-Lite register window of 256 bytes, one 32-bit word per register
// Notes:   each channel takes a 16-byte slot starting at slot index 1
package timer_pkg;

    localparam int unsigned ADDR_W = 8;

    // timer-wide register offsets
    localparam logic [7:0] TSC_OFF = 8'h00;
    localparam logic [7:0] CNT_OFF = 8'h04;
    localparam logic [7:0] MOD_OFF = 8'h08;

    // channel slot index (addr[7:4]) and word within slot (addr[3:2])
    localparam logic [3:0] TIMER_SLOT  = 4'h0;
    localparam logic [3:0] CH_BASE_IDX = 4'h1;
    localparam logic [1:0] CH_SC_SUB   = 2'h0;
    localparam logic [1:0] CH_VH_SUB   = 2'h1;
    localparam logic [1:0] CH_VL_SUB   = 2'h2;

    // field positions
    localparam int unsigned FLAG_BIT    = 7;
    localparam int unsigned TSC_CTRL_LSB = 3;
    localparam int unsigned CSC_CTRL_LSB = 2;

    // clock select codes
    localparam logic [1:0] CLK_OFF   = 2'h0;
    localparam logic [1:0] CLK_BUS   = 2'h1;
    localparam logic [1:0] CLK_FIXED = 2'h2;
    localparam logic [1:0] CLK_EXT   = 2'h3;

    // edge/level and mode codes
    localparam logic [1:0] EL_RELEASE = 2'h0;
    localparam logic [1:0] EL_RISE    = 2'h1;
    localparam logic [1:0] EL_FALL    = 2'h2;
    localparam logic [1:0] EL_BOTH    = 2'h3;
    localparam logic [1:0] MS_CAPTURE = 2'h0;
    localparam logic [1:0] MS_COMPARE = 2'h1;

    // reset values and counter limits
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] VAL_RST  = 16'h0000;
    localparam logic [15:0] MOD_RST  = 16'h0000;
    localparam logic [15:0] FREE_TOP = 16'hFFFF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       wrap_irq_enable;
        logic       centre_align_select;
        logic [1:0] clock_select;
    } timer_ctrl_s;

    typedef struct packed {
        logic       channel_irq_enable;
        logic [1:0] channel_mode;
        logic [1:0] edge_level;
    } chan_ctrl_s;

    localparam timer_ctrl_s TCTRL_RST = '{1'b0, 1'b0, CLK_OFF};
    localparam chan_ctrl_s  CCTRL_RST = '{1'b0, MS_CAPTURE, EL_RELEASE};

endpackage : timer_pkg
